// ==== rtl/dcs_pkg.sv ====
// register map, field positions and timing constants of the sync activation control bank
package dcs_pkg;
    // byte addresses, multi-byte values little endian
    localparam logic [11:0] ADDR_FILTER      = 12'h0935;
    localparam logic [11:0] ADDR_OWN         = 12'h0980;
    localparam logic [11:0] ADDR_ACT         = 12'h0981;
    localparam logic [11:0] ADDR_PLEN_LO     = 12'h0982;
    localparam logic [11:0] ADDR_PLEN_HI     = 12'h0983;
    localparam logic [11:0] ADDR_STAT_FIRST  = 12'h098E;
    localparam logic [11:0] ADDR_STAT_SECOND = 12'h098F;
    // reset values
    localparam logic [3:0]  FILTER_RST = 4'hC;
    localparam logic [7:0]  OWN_RST    = 8'h00;
    localparam logic [7:0]  ACT_RST    = 8'h00;
    localparam logic [15:0] PLEN_RST   = 16'h0000;
    // writable ownership bits
    localparam logic [7:0]  OWN_WMASK  = 8'h31;
    // ownership field positions
    localparam int OWN_SYNC   = 0;
    localparam int OWN_LATCH0 = 4;
    localparam int OWN_LATCH1 = 5;
    // activation field positions
    localparam int ACT_RUN        = 0;
    localparam int ACT_GEN_FIRST  = 1;
    localparam int ACT_GEN_SECOND = 2;
    localparam int ACT_AUTO       = 3;
    localparam int ACT_EXTEND     = 4;
    localparam int ACT_PLAUS      = 5;
    localparam int ACT_NEAR       = 6;
    localparam int ACT_DEBUG      = 7;
    // pulse length unit and clock period
    localparam int UNIT_NS = 10;
    localparam int CLK_NS  = 40;
    localparam logic [15:0] UNITS_PER_CLK = 16'(CLK_NS / UNIT_NS);
endpackage

// ==== rtl/dcs_sync_ctrl.sv ====
// distributed clock sync output activation and ownership control registers
//
// Function
// - 4-bit filter depth, resets to 12; any network write to it resets speed filter.
// - filter depth written from network side only; host side reads it.
// - ownership bit 5 gives latch unit 1 to host; its interrupt follows.
// - ownership bit 4 owns latch unit 0; reads 1 when host controls time.
// - ownership bit 0 owns sync output unit; register written by network only.
// - activation register writes accepted only from the sync unit owner.
// - writing activation bit 7 fires one debug pulse on enabled outputs.
// - activation bit 6 picks the near-future window length.
// - activation bit 5 allows immediate start when start time is implausible.
// - activation bit 4 extends a 32-bit written start time to 64 bits.
// - auto-activation sets the run bit once the start time is written.
// - bits 2 and 1 enable second and first sync pulses.
// - pulse length is a 16-bit read-only count of 10 ns units.
// - pulse length zero selects acknowledge mode; output holds until status read.
// - pulse length resets to zero unless the eeprom load overrides it.
// - multi-byte registers place the least significant byte at the lowest address.
// - in acknowledge mode a host read of a status register clears that output.
`timescale 1ns/10ps
module dcs_sync_ctrl
    import dcs_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    // network side register port
    input  wire logic [11:0] net_addr_i,
    input  wire logic [7:0]  net_wdata_i,
    input  wire logic        net_wr_i,
    input  wire logic        net_rd_i,
    output logic      [7:0]  net_rdata_o,
    // host side register port
    input  wire logic [11:0] host_addr_i,
    input  wire logic [7:0]  host_wdata_i,
    input  wire logic        host_wr_i,
    input  wire logic        host_rd_i,
    output logic      [7:0]  host_rdata_o,
    // configuration load and system state
    input  wire logic        eep_load_i,
    input  wire logic [15:0] eep_plen_i,
    input  wire logic        systime_host_ctrl_i,
    input  wire logic        start_time_written_i,
    // timing engine events and latch events
    input  wire logic        sync_evt_first_i,
    input  wire logic        sync_evt_second_i,
    input  wire logic [1:0]  latch_evt_i,
    // speed counter filter
    output logic      [3:0]  filter_depth_o,
    output logic             filter_reset_o,
    // ownership
    output logic             sync_out_host_o,
    output logic             latch0_host_o,
    output logic             latch1_host_o,
    output logic      [1:0]  latch_irq_net_o,
    output logic      [1:0]  latch_irq_host_o,
    // activation settings for the timing engine
    output logic             sync_active_o,
    output logic             near_future_short_o,
    output logic             plaus_check_o,
    output logic             extend_start_o,
    // sync outputs
    output logic             sync_pulse_first_o,
    output logic             sync_pulse_second_o
);

    logic [3:0]  filt_q;
    logic        filt_rst_q;
    logic [7:0]  own_q;
    logic [7:0]  act_q;
    logic [7:0]  act_d;
    logic [15:0] plen_q;
    logic [15:0] rem_q [2];
    logic [1:0]  sync_q;
    logic        l0_host_q;
    logic [1:0]  irq_net_q;
    logic [1:0]  irq_host_q;
    logic [7:0]  net_rdata_q;
    logic [7:0]  host_rdata_q;

    // effective ownership view, bit 4 forced while host controls system time
    wire  [7:0] own_view = (own_q & OWN_WMASK) | ({7'h00, systime_host_ctrl_i} << OWN_LATCH0);
    wire  [1:0] latch_host = {own_q[OWN_LATCH1], own_view[OWN_LATCH0]};

    // write decode
    wire net_we_filt = net_wr_i && (net_addr_i == ADDR_FILTER);
    wire net_we_own  = net_wr_i && (net_addr_i == ADDR_OWN);
    wire net_we_act  = net_wr_i && (net_addr_i == ADDR_ACT) && !own_q[OWN_SYNC];
    wire host_we_act = host_wr_i && (host_addr_i == ADDR_ACT) && own_q[OWN_SYNC];
    wire act_wr      = net_we_act || host_we_act;
    wire [7:0] act_wdata = own_q[OWN_SYNC] ? host_wdata_i : net_wdata_i;
    wire auto_set    = act_q[ACT_AUTO] && start_time_written_i;

    // sync pulse triggers
    wire ack_mode  = (plen_q == PLEN_RST);
    wire dbg_fire  = act_wr && act_wdata[ACT_DEBUG];
    wire [1:0] trig;
    assign trig[0] = (dbg_fire && act_wdata[ACT_GEN_FIRST])
                   || (sync_evt_first_i && act_q[ACT_RUN] && act_q[ACT_GEN_FIRST]);
    assign trig[1] = (dbg_fire && act_wdata[ACT_GEN_SECOND])
                   || (sync_evt_second_i && act_q[ACT_RUN] && act_q[ACT_GEN_SECOND]);
    wire [1:0] ack_clr;
    assign ack_clr[0] = ack_mode && host_rd_i && (host_addr_i == ADDR_STAT_FIRST);
    assign ack_clr[1] = ack_mode && host_rd_i && (host_addr_i == ADDR_STAT_SECOND);

    // read decode shared by both ports
    function automatic logic [7:0] rd_mux(input logic [11:0] a);
        logic [7:0] r;
        r = 8'h00;
        unique case (a)
            ADDR_FILTER:      r = {4'h0, filt_q};
            ADDR_OWN:         r = own_view;
            ADDR_ACT:         r = act_q;
            ADDR_PLEN_LO:     r = plen_q[7:0];
            ADDR_PLEN_HI:     r = plen_q[15:8];
            ADDR_STAT_FIRST:  r = {7'h00, sync_q[0]};
            ADDR_STAT_SECOND: r = {7'h00, sync_q[1]};
            default:          r = 8'h00;
        endcase
        return r;
    endfunction

    // activation next value, auto-activation wins over a same-cycle write
    always_comb begin
        act_d = act_q;
        if (act_wr) begin
            act_d = act_wdata;
        end
        if (auto_set) begin
            act_d[ACT_RUN] = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            filt_q     <= FILTER_RST;
            filt_rst_q <= 1'b0;
        end else begin
            filt_rst_q <= net_we_filt;
            if (net_we_filt) begin
                filt_q <= net_wdata_i[3:0];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            own_q <= OWN_RST;
        end else if (net_we_own) begin
            own_q <= net_wdata_i & OWN_WMASK;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            act_q <= ACT_RST;
        end else begin
            act_q <= act_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            plen_q <= PLEN_RST;
        end else if (eep_load_i) begin
            plen_q <= eep_plen_i;
        end
    end

    // pulse shaping: timed mode counts units, acknowledge mode holds until read
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            sync_q <= 2'b00;
            for (int i = 0; i < 2; i++) begin
                rem_q[i] <= PLEN_RST;
            end
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (trig[i]) begin
                    sync_q[i] <= 1'b1;
                    rem_q[i]  <= plen_q;
                end else if (ack_mode) begin
                    if (ack_clr[i]) begin
                        sync_q[i] <= 1'b0;
                    end
                end else if (rem_q[i] > UNITS_PER_CLK) begin
                    rem_q[i] <= rem_q[i] - UNITS_PER_CLK;
                end else begin
                    rem_q[i]  <= PLEN_RST;
                    sync_q[i] <= 1'b0;
                end
            end
        end
    end

    // latch interrupt routing to the owning side
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            l0_host_q  <= 1'b0;
            irq_net_q  <= 2'b00;
            irq_host_q <= 2'b00;
        end else begin
            l0_host_q  <= own_view[OWN_LATCH0];
            irq_net_q  <= latch_evt_i & ~latch_host;
            irq_host_q <= latch_evt_i & latch_host;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            net_rdata_q  <= 8'h00;
            host_rdata_q <= 8'h00;
        end else begin
            if (net_rd_i) begin
                net_rdata_q <= rd_mux(net_addr_i);
            end
            if (host_rd_i) begin
                host_rdata_q <= rd_mux(host_addr_i);
            end
        end
    end

    assign net_rdata_o         = net_rdata_q;
    assign host_rdata_o        = host_rdata_q;
    assign filter_depth_o      = filt_q;
    assign filter_reset_o      = filt_rst_q;
    assign sync_out_host_o     = own_q[OWN_SYNC];
    assign latch0_host_o       = l0_host_q;
    assign latch1_host_o       = own_q[OWN_LATCH1];
    assign latch_irq_net_o     = irq_net_q;
    assign latch_irq_host_o    = irq_host_q;
    assign sync_active_o       = act_q[ACT_RUN];
    assign near_future_short_o = act_q[ACT_NEAR];
    assign plaus_check_o       = act_q[ACT_PLAUS];
    assign extend_start_o      = act_q[ACT_EXTEND];
    assign sync_pulse_first_o  = sync_q[0];
    assign sync_pulse_second_o = sync_q[1];

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    sequence s_short_trig;
        trig[0] && plen_q != PLEN_RST && plen_q <= UNITS_PER_CLK && !eep_load_i;
    endsequence
    sequence s_no_retrig;
        !trig[0];
    endsequence

    property p_filter_write;
        net_we_filt |=> filter_reset_o && filter_depth_o == $past(net_wdata_i[3:0]);
    endproperty
    a_filter_write: assert property (p_filter_write) else $error("filter write not applied");

    property p_filter_host_ro;
        host_wr_i && host_addr_i == ADDR_FILTER && !net_we_filt |=> $stable(filter_depth_o);
    endproperty
    a_filter_host_ro: assert property (p_filter_host_ro) else $error("host changed filter depth");

    property p_latch1_route;
        latch_evt_i[1] && own_q[OWN_LATCH1] |=> latch_irq_host_o[1] && !latch_irq_net_o[1];
    endproperty
    a_latch1_route: assert property (p_latch1_route) else $error("latch 1 irq misrouted");

    property p_latch0_forced;
        systime_host_ctrl_i |=> latch0_host_o;
    endproperty
    a_latch0_forced: assert property (p_latch0_forced) else $error("latch 0 not host owned");

    property p_own_host_ro;
        host_wr_i && host_addr_i == ADDR_OWN && !net_we_own |=> $stable(own_q);
    endproperty
    a_own_host_ro: assert property (p_own_host_ro) else $error("host changed ownership");

    property p_act_owner;
        !act_wr && !auto_set |=> $stable(act_q);
    endproperty
    a_act_owner: assert property (p_act_owner) else $error("activation changed by non-owner");

    property p_debug_pulse;
        act_wr && act_wdata[ACT_DEBUG] && act_wdata[ACT_GEN_FIRST] |=> sync_pulse_first_o;
    endproperty
    a_debug_pulse: assert property (p_debug_pulse) else $error("debug pulse missing");

    property p_auto_act;
        auto_set |=> sync_active_o;
    endproperty
    a_auto_act: assert property (p_auto_act) else $error("auto-activation missing");

    property p_gen_off;
        sync_evt_first_i && !act_q[ACT_GEN_FIRST] && !dbg_fire && !sync_q[0] |=> !sync_pulse_first_o;
    endproperty
    a_gen_off: assert property (p_gen_off) else $error("disabled pulse produced");

    property p_short_len;
        s_short_trig ##1 s_no_retrig |=> !sync_pulse_first_o;
    endproperty
    a_short_len: assert property (p_short_len) else $error("pulse longer than length");

    property p_ack_hold;
        ack_mode && sync_q[0] && !ack_clr[0] && !eep_load_i |=> sync_pulse_first_o;
    endproperty
    a_ack_hold: assert property (p_ack_hold) else $error("ack mode output dropped");

    property p_eep_load;
        eep_load_i |=> plen_q == $past(eep_plen_i);
    endproperty
    a_eep_load: assert property (p_eep_load) else $error("pulse length not loaded");

    property p_plen_hi;
        net_rd_i && net_addr_i == ADDR_PLEN_HI |=> net_rdata_o == $past(plen_q[15:8]);
    endproperty
    a_plen_hi: assert property (p_plen_hi) else $error("pulse length high byte wrong");

    property p_own_reserved;
        host_rd_i && host_addr_i == ADDR_OWN |=> host_rdata_o[7:6] == 2'b00 && host_rdata_o[3:1] == 3'h0;
    endproperty
    a_own_reserved: assert property (p_own_reserved) else $error("reserved bits not zero");

    property p_ack_clear;
        ack_clr[0] && !trig[0] |=> !sync_pulse_first_o;
    endproperty
    a_ack_clear: assert property (p_ack_clear) else $error("status read did not clear");

endmodule

// ==== verif/dcs_bus_agent.sv ====
// register port agent standing in for the network master or the host controller
`timescale 1ns/10ps
module dcs_bus_agent (
    // clock
    input  wire logic        clk_i,
    // register port
    output logic      [11:0] addr_o,
    output logic      [7:0]  wdata_o,
    output logic             wr_o,
    output logic             rd_o
);
    initial begin
        addr_o  = 12'h0000;
        wdata_o = 8'h00;
        wr_o    = 1'b0;
        rd_o    = 1'b0;
    end

    // one strobe cycle; afterwards address and data show the inverse, not the last value
    task automatic access(input logic [11:0] a, input logic [7:0] d, input logic w);
        @(posedge clk_i);
        addr_o  <= a;
        wdata_o <= d;
        wr_o    <= w;
        rd_o    <= !w;
        @(posedge clk_i);
        addr_o  <= ~a;
        wdata_o <= ~d;
        wr_o    <= 1'b0;
        rd_o    <= 1'b0;
    endtask
endmodule

// ==== verif/dcs_sync_ctrl_tb.sv ====
// self-checking bench for the sync activation control register bank
`timescale 1ns/10ps
module dcs_sync_ctrl_tb
    import dcs_pkg::*;
;
    logic        clk_i = 1'b0;
    logic        reset_i = 1'b1;
    logic [11:0] net_addr_i, host_addr_i;
    logic [7:0]  net_wdata_i, host_wdata_i, net_rdata_o, host_rdata_o;
    logic        net_wr_i, net_rd_i, host_wr_i, host_rd_i;
    logic [5:0]  ev = 6'h00;
    logic [15:0] eep_plen_i = 16'h0000;
    logic        systime_host_ctrl_i = 1'b0;
    logic [3:0]  filter_depth_o;
    logic        filter_reset_o, sync_out_host_o, latch0_host_o, latch1_host_o;
    logic [1:0]  latch_irq_net_o, latch_irq_host_o;
    logic        sync_active_o, near_future_short_o, plaus_check_o, extend_start_o;
    logic        sync_pulse_first_o, sync_pulse_second_o;
    logic [7:0]  net_q[$], host_q[$];
    int          cnt[7] = '{default: 0};
    int          snap[7];
    int          err_total = 0;
    int          samples_checked = 0;
    logic [7:0]  d;
    logic [15:0] len;
    logic        nrd_q = 1'b0, hrd_q = 1'b0;
    logic [11:0] rst_a[6] = '{ADDR_FILTER, ADDR_OWN, ADDR_ACT, ADDR_PLEN_LO, ADDR_PLEN_HI, 12'h0FF0};
    logic [7:0]  rst_v[6] = '{{4'h0, FILTER_RST}, OWN_RST, ACT_RST, PLEN_RST[7:0], PLEN_RST[15:8], 8'h00};
    wire  logic [6:0] mon = {latch_irq_host_o, latch_irq_net_o, sync_pulse_second_o, sync_pulse_first_o,
                             filter_reset_o};

    always #20 clk_i = ~clk_i;

    dcs_sync_ctrl i_dcs_sync_ctrl (
        .clk_i, .reset_i, .net_addr_i, .net_wdata_i, .net_wr_i, .net_rd_i, .net_rdata_o,
        .host_addr_i, .host_wdata_i, .host_wr_i, .host_rd_i, .host_rdata_o,
        .eep_load_i(ev[5]), .eep_plen_i, .systime_host_ctrl_i, .start_time_written_i(ev[0]),
        .sync_evt_first_i(ev[1]), .sync_evt_second_i(ev[2]), .latch_evt_i(ev[4:3]),
        .filter_depth_o, .filter_reset_o, .sync_out_host_o, .latch0_host_o, .latch1_host_o,
        .latch_irq_net_o, .latch_irq_host_o, .sync_active_o, .near_future_short_o, .plaus_check_o,
        .extend_start_o, .sync_pulse_first_o, .sync_pulse_second_o
    );
    dcs_bus_agent i_net (.clk_i, .addr_o(net_addr_i), .wdata_o(net_wdata_i), .wr_o(net_wr_i), .rd_o(net_rd_i));
    dcs_bus_agent i_host (.clk_i, .addr_o(host_addr_i), .wdata_o(host_wdata_i), .wr_o(host_wr_i),
                          .rd_o(host_rd_i));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop;
        if (err_total == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // read data is compared the cycle after the strobe; cycles with an output high are counted
    always @(posedge clk_i) begin
        nrd_q <= net_rd_i;
        hrd_q <= host_rd_i;
        if (nrd_q) check(16'(net_rdata_o), 16'(net_q.pop_front()));
        if (hrd_q) check(16'(host_rdata_o), 16'(host_q.pop_front()));
        for (int k = 0; k < 7; k++) if (mon[k] === 1'b1) cnt[k]++;
    end

    task automatic nw(input logic [11:0] a, input logic [7:0] v);
        i_net.access(a, v, 1'b1);
    endtask
    task automatic hw(input logic [11:0] a, input logic [7:0] v);
        i_host.access(a, v, 1'b1);
    endtask
    task automatic nr(input logic [11:0] a, input logic [7:0] e);
        net_q.push_back(e);
        i_net.access(a, 8'h00, 1'b0);
    endtask
    task automatic hr(input logic [11:0] a, input logic [7:0] e);
        host_q.push_back(e);
        i_host.access(a, 8'h00, 1'b0);
    endtask
    task automatic pulse(input logic [5:0] m);
        @(posedge clk_i);
        ev <= m;
        @(posedge clk_i);
        ev <= 6'h00;
        repeat (3) @(posedge clk_i);
    endtask
    task automatic delta(input int k, input int e);
        check(16'(cnt[k] - snap[k]), 16'(e));
    endtask

    initial begin
        repeat (20000) @(posedge clk_i);
        err_total++;
        report_and_stop;
    end

    initial begin
        void'($urandom(32'hc270));
        repeat (8) @(posedge clk_i);
        reset_i <= 1'b0;
        @(negedge clk_i);
        check(16'(filter_depth_o), 16'(FILTER_RST));
        for (int i = 0; i < 6; i++) begin
            nr(rst_a[i], rst_v[i]);
            hr(rst_a[i], rst_v[i]);
        end
        d = 8'($urandom) | 8'h01;
        snap = cnt;
        nw(ADDR_FILTER, d);
        hw(ADDR_FILTER, ~d);
        nr(ADDR_FILTER, {4'h0, d[3:0]});
        hr(ADDR_FILTER, {4'h0, d[3:0]});
        delta(0, 1);
        check(16'(filter_depth_o), 16'(d[3:0]));
        hw(ADDR_OWN, 8'h01);
        nr(ADDR_OWN, 8'h00);
        nw(ADDR_OWN, 8'hFF);
        nr(ADDR_OWN, OWN_WMASK);
        hr(ADDR_OWN, OWN_WMASK);
        check(16'({sync_out_host_o, latch0_host_o, latch1_host_o}), 16'h0007);
        snap = cnt;
        pulse(6'h18);
        delta(5, 1);
        delta(6, 1);
        delta(3, 0);
        nw(ADDR_ACT, 8'h01);
        hw(ADDR_ACT, 8'h70);
        hr(ADDR_ACT, 8'h70);
        check(16'({sync_active_o, near_future_short_o, plaus_check_o, extend_start_o}), 16'h0007);
        nw(ADDR_OWN, 8'h00);
        systime_host_ctrl_i <= 1'b1;
        nr(ADDR_OWN, 8'h10);
        hw(ADDR_ACT, 8'h00);
        nr(ADDR_ACT, 8'h70);
        snap = cnt;
        pulse(6'h08);
        systime_host_ctrl_i <= 1'b0;
        pulse(6'h10);
        delta(5, 1);
        delta(4, 1);
        len = 16'($urandom);
        eep_plen_i <= len;
        pulse(6'h20);
        nw(ADDR_PLEN_LO, ~len[7:0]);
        nr(ADDR_PLEN_LO, len[7:0]);
        hr(ADDR_PLEN_HI, len[15:8]);
        len = 16'($urandom_range(40, 1));
        eep_plen_i <= len;
        pulse(6'h20);
        snap = cnt;
        nw(ADDR_ACT, 8'h82);
        repeat (12) @(posedge clk_i);
        delta(1, (len + 3) / 4);
        delta(2, 0);
        nw(ADDR_ACT, 8'h84);
        repeat (12) @(posedge clk_i);
        delta(2, (len + 3) / 4);
        snap = cnt;
        pulse(6'h01);
        nw(ADDR_ACT, 8'h03);
        pulse(6'h06);
        repeat (12) @(posedge clk_i);
        delta(1, (len + 3) / 4);
        delta(2, 0);
        nw(ADDR_ACT, 8'h08);
        @(negedge clk_i);
        check(16'(sync_active_o), 16'h0000);
        pulse(6'h01);
        nr(ADDR_ACT, 8'h09);
        eep_plen_i <= 16'h0000;
        pulse(6'h20);
        nw(ADDR_ACT, 8'h03);
        pulse(6'h02);
        repeat (20) @(posedge clk_i);
        nr(ADDR_STAT_FIRST, 8'h01);
        @(negedge clk_i);
        check(16'(sync_pulse_first_o), 16'h0001);
        hr(ADDR_STAT_FIRST, 8'h01);
        @(negedge clk_i);
        check(16'(sync_pulse_first_o), 16'h0000);
        nw(ADDR_ACT, 8'h05);
        pulse(6'h04);
        @(negedge clk_i);
        check(16'(sync_pulse_second_o), 16'h0001);
        hr(ADDR_STAT_SECOND, 8'h01);
        @(negedge clk_i);
        check(16'(sync_pulse_second_o), 16'h0000);
        // let the last queued read reach the monitor before closing
        repeat (2) @(negedge clk_i);
        check(16'(net_q.size() + host_q.size()), 16'h0000);
        report_and_stop;
    end
endmodule
